/* dv/apc_audio_partner.sv */
// Behavioural audio sources and output sink facing the panel control block
`timescale 1ns/1ns
module apc_audio_partner (
	input  wire logic        clock,
	input  wire logic        srcReady,
	input  wire logic [23:0] outData,
	input  wire logic        outValid,
	input  wire logic [1:0]  sinkMode,
	output logic      [23:0] aesData,
	output logic             aesValid,
	output logic      [23:0] spdifData,
	output logic             spdifValid,
	output logic      [23:0] adcData,
	output logic             adcValid,
	output logic             outReady
);
	logic [23:0] rxQ[$];
	logic        toggle = 1'h0;

	initial begin
		{aesData, spdifData, adcData} = '0;
		{aesValid, spdifValid, adcValid, outReady} = '0;
	end

	// ********************************
	// Sources: one 24-bit word per take
	// ********************************
	task automatic send(input logic [1:0] sel, input logic [23:0] v);
		@(posedge clock);
		aesData <= v;
		spdifData <= v;
		adcData <= v;
		aesValid <= (sel == 2'h0);
		spdifValid <= (sel == 2'h1);
		adcValid <= (sel == 2'h2);
		do @(posedge clock); while (srcReady !== 1'h1);
		{aesValid, spdifValid, adcValid} <= 3'h0;
		// Released lines show the inverse, so a stale word can never pass for a match
		aesData <= ~v;
		spdifData <= ~v;
		adcData <= ~v;
	endtask

	// ********************************
	// Sink: mode 0 ready, 1 stalled, 2 every other cycle
	// ********************************
	always @(posedge clock) begin
		if (outValid === 1'h1 && outReady === 1'h1)
			rxQ.push_back(outData);
		toggle <= ~toggle;
		outReady <= (sinkMode == 2'h0) || (sinkMode == 2'h2 && toggle);
	end
endmodule

/* dv/audio_panel_mode_control_tb_top.sv */
// Self-checking bench for the panel mode control block
`timescale 1ns/1ns
module audio_panel_mode_control_tb_top;
	logic        clock = 1'h0;
	logic        sys_rst = 1'h1;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic        regWr = 1'h0;
	logic        regRd = 1'h0;
	logic [31:0] regRdData;
	logic        extSyncPresent = 1'h0;
	logic        extSampleSync = 1'h0;
	logic        overClearBtn = 1'h0;
	logic        peakJumper = 1'h0;
	logic [23:0] aesData, spdifData, adcData, outData;
	logic        aesValid, spdifValid, adcValid, srcReady, outValid, outReady;
	logic        outToDac, lockLed, adcRecal, wordClkOut, overLed, ditherEn;
	logic [2:0]  rateCode;
	logic [1:0]  sinkMode = 2'h0;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;

	apc_panel_ctrl #(.HOLD_CYC(50), .DECAY_CYC(10), .RAMP_SHIFT(2)) i_apc_panel_ctrl (
		.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .extSyncPresent(extSyncPresent), .extSampleSync(extSampleSync),
		.overClearBtn(overClearBtn), .peakJumper(peakJumper), .aesData(aesData), .aesValid(aesValid),
		.spdifData(spdifData), .spdifValid(spdifValid), .adcData(adcData), .adcValid(adcValid),
		.srcReady(srcReady), .outData(outData), .outValid(outValid), .outReady(outReady),
		.outToDac(outToDac), .rateCode(rateCode), .lockLed(lockLed), .adcRecal(adcRecal),
		.wordClkOut(wordClkOut), .overLed(overLed), .ditherEn(ditherEn));
	apc_audio_partner i_apc_audio_partner (
		.clock(clock), .srcReady(srcReady), .outData(outData), .outValid(outValid), .sinkMode(sinkMode),
		.aesData(aesData), .aesValid(aesValid), .spdifData(spdifData), .spdifValid(spdifValid),
		.adcData(adcData), .adcValid(adcValid), .outReady(outReady));

	always #5 clock = ~clock;

	// External reference toggles slowly; the ceiling covers four full word-clock measurements
	always @(posedge clock) begin
		cycles++;
		if (cycles % 50 == 0)
			extSampleSync <= ~extSampleSync;
		if (cycles >= 40000) begin
			num_errors++;
			wrap_up();
		end
	end

	// ********************************
	// Helpers
	// ********************************
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, 32'(e), 32'(g));
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge clock);
		regWr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clock);
		regRd <= 1'h0;
		#1 d = regRdData;
	endtask
	function automatic logic [31:0] ctl(input logic [1:0] rt, input logic ex, by, ins, input logic [1:0] ro, wl);
		return {23'h0, wl, ro, ins, by, ex, rt};
	endfunction
	task automatic wait_rx(input int n);
		for (int i = 0; i < 300 && i_apc_audio_partner.rxQ.size() < n; i++)
			@(posedge clock);
		#1;
	endtask
	task automatic wc_half(output int n);
		logic w;
		w = wordClkOut;
		repeat (3) begin
			for (n = 0; n < 2000 && wordClkOut === w; n++)
				tick(1);
			w = wordClkOut;
		end
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset;
		logic [31:0] d;
		chk("rateCode", 32'h0, 32'(rateCode));
		chkb("lockLed", 1'h0, lockLed);
		chkb("overLed", 1'h0, overLed);
		chkb("ditherEn", 1'h0, ditherEn);
		rd(apc_pkg::OFS_CTRL, d);
		chk("ctrl", 32'(apc_pkg::CTRL_RESET), d);
		wr(apc_pkg::OFS_STATUS, 32'hFFFFFFFF);
		rd(apc_pkg::OFS_STATUS, d);
		chk("status", 32'h0, d);
		rd(apc_pkg::OFS_CMD, d);
		chk("cmd", 32'h0, d);
		rd(8'h10, d);
		chk("unmapped", 32'h0, d);
	endtask
	task automatic t_rate;
		logic [10:0] hv[4] = '{apc_pkg::HALF_A, apc_pkg::HALF_B, apc_pkg::HALF_C, apc_pkg::HALF_D};
		int n;
		for (int r = 3; r >= 0; r--) begin
			wr(apc_pkg::OFS_CTRL, ctl(2'(r), 1'h0, 1'h0, 1'h0, apc_pkg::ROUTE_DA, apc_pkg::WL_24));
			tick(1);
			chk("rateCode", 32'(r), 32'(rateCode));
			chkb("adcRecal", 1'h1, adcRecal);
			tick(1);
			chkb("adcRecal end", 1'h0, adcRecal);
			wc_half(n);
			chk("wcHalf", 32'(hv[r]), 32'(n));
		end
	endtask
	task automatic t_ext;
		@(posedge clock) extSyncPresent <= 1'h1;
		tick(6);
		chkb("lock unselected", 1'h0, lockLed);
		wr(apc_pkg::OFS_CTRL, ctl(2'h1, 1'h1, 1'h0, 1'h0, apc_pkg::ROUTE_DA, apc_pkg::WL_24));
		tick(6);
		chk("rateCode ext", 32'(apc_pkg::RATE_EXT), 32'(rateCode));
		chkb("lockLed", 1'h1, lockLed);
		@(posedge clock) extSyncPresent <= 1'h0;
		tick(6);
		chk("rateCode loss", 32'(apc_pkg::RATE_44K1), 32'(rateCode));
		chkb("lockLed loss", 1'h0, lockLed);
	endtask
	task automatic t_stream;
		int n;
		wr(apc_pkg::OFS_CTRL, ctl(2'h0, 1'h0, 1'h0, 1'h0, apc_pkg::ROUTE_DD, apc_pkg::WL_16));
		tick(2);
		i_apc_audio_partner.send(2'h0, 24'hA5A5A5);
		i_apc_audio_partner.send(2'h1, 24'h5A5A5A);
		i_apc_audio_partner.send(2'h0, 24'h1234AB);
		wait_rx(2);
		chk("rx count", 32'h2, 32'(i_apc_audio_partner.rxQ.size()));
		chk("rx0", 32'h00A5A5A5, 32'(i_apc_audio_partner.rxQ[0]));
		chk("rx1", 32'h001234AB, 32'(i_apc_audio_partner.rxQ[1]));
		i_apc_audio_partner.rxQ.delete();
		sinkMode <= 2'h1;
		for (n = 0; n < 40; n++) begin
			tick(1);
			if (srcReady !== 1'h1)
				break;
			i_apc_audio_partner.send(2'h0, 24'h0B0000 + 24'(n));
		end
		chkb("full", 1'h1, n >= 16 && n < 40);
		sinkMode <= 2'h2;
		wait_rx(n);
		chk("drained", 32'(n), 32'(i_apc_audio_partner.rxQ.size()));
		for (int i = 0; i < n && i < i_apc_audio_partner.rxQ.size(); i++)
			chk("fifo", 32'h0B0000 + 32'(i), 32'(i_apc_audio_partner.rxQ[i]));
		chkb("ready again", 1'h1, srcReady);
		sinkMode <= 2'h0;
		for (int r = 0; r < 4; r++) begin
			i_apc_audio_partner.rxQ.delete();
			wr(apc_pkg::OFS_CTRL, ctl(2'h0, 1'h0, 1'(r), 1'h1, 2'(r), apc_pkg::WL_24));
			tick(2);
			chkb("outToDac", r == 0 || r == 3, outToDac);
			i_apc_audio_partner.send((r == 1 || r == 3) ? 2'h2 : 2'h1, 24'h300000 + 24'(r));
			wait_rx(1);
			chk("route", 32'h300000 + 32'(r), 32'(i_apc_audio_partner.rxQ[0]));
		end
	endtask
	task automatic t_dither;
		for (int r = 0; r < 4; r++)
			for (int w = 0; w < 3; w++) begin
				wr(apc_pkg::OFS_CTRL, ctl(2'h0, 1'h0, 1'h0, 1'h0, 2'(r), 2'(w)));
				tick(2);
				chkb("ditherEn", (r == 1 || r == 2) && (w == 1 || w == 2), ditherEn);
			end
	endtask
	task automatic t_over;
		logic [31:0] d;
		wr(apc_pkg::OFS_CTRL, ctl(2'h0, 1'h0, 1'h0, 1'h0, apc_pkg::ROUTE_DD, apc_pkg::WL_24));
		tick(2);
		i_apc_audio_partner.send(2'h0, 24'h7FFFFF);
		tick(2);
		chkb("overLed", 1'h1, overLed);
		rd(apc_pkg::OFS_STATUS, d);
		chkb("status over", 1'h1, d[6]);
		rd(apc_pkg::OFS_PEAK, d);
		chk("peak", 32'h007FFFFF, d);
		wr(apc_pkg::OFS_CMD, 32'h1);
		tick(1);
		chkb("overLed cmd", 1'h0, overLed);
		rd(apc_pkg::OFS_PEAK, d);
		chk("peak cleared", 32'h0, d);
		i_apc_audio_partner.send(2'h0, 24'h800000);
		tick(2);
		chkb("overLed neg", 1'h1, overLed);
		@(posedge clock) overClearBtn <= 1'h1;
		tick(6);
		chkb("overLed btn", 1'h0, overLed);
		@(posedge clock) overClearBtn <= 1'h0;
		i_apc_audio_partner.send(2'h0, 24'h7FFFFE);
		tick(2);
		chkb("below full", 1'h0, overLed);
		wr(apc_pkg::OFS_CMD, 32'h1);
		i_apc_audio_partner.send(2'h0, 24'h400000);
		tick(200);
		rd(apc_pkg::OFS_PEAK, d);
		chk("peak held", 32'h00400000, d);
		@(posedge clock) peakJumper <= 1'h1;
		tick(200);
		rd(apc_pkg::OFS_PEAK, d);
		chkb("peak decayed", 1'h1, d < 32'h00400000);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		sys_rst <= 1'h0;
		tick(2);
		t_reset();
		t_rate();
		t_ext();
		t_stream();
		t_dither();
		t_over();
		wrap_up();
	end
endmodule

/* src/apc_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module apc_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	wire              doWr = inValid & inReady;
	wire              doRd = outValid & outReady;

	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];
	assign next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);

	// Ready is registered so the source sees a clean flop output
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wrPtr   <= '0;
			rdPtr   <= '0;
			count   <= '0;
			inReady <= 1'b0;
		end else begin
			if (doWr) begin
				mem[wrPtr] <= inData;
				wrPtr      <= wrPtr + 1'b1;
			end
			if (doRd)
				rdPtr <= rdPtr + 1'b1;
			count   <= next_count;
			inReady <= (next_count < (AW+1)'(DEPTH));
		end
	end
endmodule

/* src/apc_panel_ctrl.sv */
// Panel mode control: rate, lock, calibration, overload, peak, bypass and routing
//
// Behaviour
// - Rate from internal set or external reference
// - Lock lamp when external selected and locked
// - Lock loss forces 44.1 kHz, lamp off
// - Any rate change starts converter recalibration
// - Clear control resets overload and peak
// - Bypass applied gradually to avoid clicks
// - Input selector picks AES or S/PDIF
// - Triode, pentode, tape stages in series
// - Routing places chain on four paths
// - Dither only AD/DD with 16/20 group
// - Datapath and digital ports 24 bits
// - Full width results, never truncated; code drops the low RAMP_SHIFT bits of the gain product
// - Overload on full-scale sample, routing-selected source
// - Peak hold: timed decay or hold forever
// - Word clock follows current converter rate
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
module apc_panel_ctrl #(
	parameter int SW          = 24,
	parameter int FIFO_DEPTH  = 16,
	parameter int RAMP_SHIFT  = apc_pkg::RAMP_SHIFT,
	parameter int HOLD_CYC    = apc_pkg::PEAK_HOLD_CYC,
	parameter int DECAY_CYC   = apc_pkg::DECAY_STEP_CYC
) (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic [7:0]    regAddr,
	input  wire logic [31:0]   regWrData,
	input  wire logic          regWr,
	input  wire logic          regRd,
	output logic      [31:0]   regRdData,
	input  wire logic          extSyncPresent,
	input  wire logic          extSampleSync,
	input  wire logic          overClearBtn,
	input  wire logic          peakJumper,
	input  wire logic [SW-1:0] aesData,
	input  wire logic          aesValid,
	input  wire logic [SW-1:0] spdifData,
	input  wire logic          spdifValid,
	input  wire logic [SW-1:0] adcData,
	input  wire logic          adcValid,
	output logic               srcReady,
	output logic      [SW-1:0] outData,
	output logic               outValid,
	input  wire logic          outReady,
	output logic               outToDac,
	output logic      [2:0]    rateCode,
	output logic               lockLed,
	output logic               adcRecal,
	output logic               wordClkOut,
	output logic               overLed,
	output logic               ditherEn
);
	localparam int GW = RAMP_SHIFT + 1;
	localparam logic [GW-1:0] GMAX = GW'(1 << RAMP_SHIFT);

	// ********************************
	// Pin synchronisers
	// ********************************
	logic [1:0] syncPres;
	logic [1:0] syncClk;
	logic [1:0] syncBtn;
	logic [1:0] syncJmp;
	logic       clkDly;
	logic       btnDly;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			syncPres <= 2'h0;
			syncClk  <= 2'h0;
			syncBtn  <= 2'h0;
			syncJmp  <= 2'h0;
			clkDly   <= 1'b0;
			btnDly   <= 1'b0;
		end else begin
			syncPres <= {syncPres[0], extSyncPresent};
			syncClk  <= {syncClk[0], extSampleSync};
			syncBtn  <= {syncBtn[0], overClearBtn};
			syncJmp  <= {syncJmp[0], peakJumper};
			clkDly   <= syncClk[1];
			btnDly   <= syncBtn[1];
		end
	end

	// ********************************
	// Register file
	// ********************************
	logic [8:0]    ctrl;
	logic [SW-1:0] peak;
	wire  wrCtrl   = regWr & (regAddr == apc_pkg::OFS_CTRL);
	wire  wrCmd    = regWr & (regAddr == apc_pkg::OFS_CMD);
	wire  [1:0] rateSel = ctrl[apc_pkg::CTRL_RATE_LSB +: 2];
	wire  extSel   = ctrl[apc_pkg::CTRL_EXT_BIT];
	wire  bypass   = ctrl[apc_pkg::CTRL_BYP_BIT];
	wire  inSel    = ctrl[apc_pkg::CTRL_INSEL_BIT];
	wire  [1:0] route = ctrl[apc_pkg::CTRL_ROUTE_LSB +: 2];
	wire  [1:0] wordLen = ctrl[apc_pkg::CTRL_WL_LSB +: 2];
	wire  clearReq = (wrCmd & regWrData[apc_pkg::CMD_CLR_BIT]) | (syncBtn[1] & ~btnDly);
	wire  [31:0] statusWord = {24'h0, ditherEn, overLed, adcRecal, lockLed, syncPres[1], rateCode};
	wire  [31:0] rdMux =
		(regAddr == apc_pkg::OFS_CTRL)   ? {23'h0, ctrl} :
		(regAddr == apc_pkg::OFS_STATUS) ? statusWord :
		(regAddr == apc_pkg::OFS_PEAK)   ? 32'(peak) : 32'h0;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl      <= apc_pkg::CTRL_RESET;
			regRdData <= 32'h0;
		end else begin
			if (wrCtrl)
				ctrl <= regWrData[8:0];
			regRdData <= regRd ? rdMux : 32'h0;
		end
	end

	// ********************************
	// Sample rate, lock and recalibration
	// ********************************
	wire locked = extSel & syncPres[1];
	// Lost lock falls back to the lowest internal rate
	wire [2:0] next_rate = extSel ? (syncPres[1] ? apc_pkg::RATE_EXT : apc_pkg::RATE_44K1)
	                              : {1'b0, rateSel};
	wire [10:0] halfCnt =
		(rateCode == apc_pkg::RATE_48K)  ? apc_pkg::HALF_B :
		(rateCode == apc_pkg::RATE_88K2) ? apc_pkg::HALF_C :
		(rateCode == apc_pkg::RATE_96K)  ? apc_pkg::HALF_D : apc_pkg::HALF_A;
	logic [10:0] wcCnt;
	logic        wcInt;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rateCode <= apc_pkg::RATE_44K1;
			lockLed  <= 1'b0;
			adcRecal <= 1'b0;
		end else begin
			rateCode <= next_rate;
			lockLed  <= locked;
			adcRecal <= (next_rate != rateCode);
		end
	end

	// Internal word clock from a divider; the external one is passed through
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wcCnt      <= 11'h000;
			wcInt      <= 1'b0;
			wordClkOut <= 1'b0;
		end else begin
			if (wcCnt >= halfCnt - 11'h001) begin
				wcCnt <= 11'h000;
				wcInt <= ~wcInt;
			end else
				wcCnt <= wcCnt + 11'h001;
			wordClkOut <= (rateCode == apc_pkg::RATE_EXT) ? clkDly : wcInt;
		end
	end

	// ********************************
	// Source selection and routing
	// ********************************
	wire analogSrc = (route == apc_pkg::ROUTE_AD) | (route == apc_pkg::ROUTE_AA);
	wire [SW-1:0] digData  = inSel ? spdifData : aesData;
	wire          digValid = inSel ? spdifValid : aesValid;
	wire [SW-1:0] srcData  = analogSrc ? adcData : digData;
	wire          srcValid = analogSrc ? adcValid : digValid;
	wire          wlDither = (wordLen == apc_pkg::WL_16) | (wordLen == apc_pkg::WL_20);
	wire          rtDither = (route == apc_pkg::ROUTE_AD) | (route == apc_pkg::ROUTE_DD);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ditherEn <= 1'b0;
			outToDac <= 1'b0;
		end else begin
			ditherEn <= wlDither & rtDither;
			outToDac <= (route == apc_pkg::ROUTE_DA) | (route == apc_pkg::ROUTE_AA);
		end
	end

	// ********************************
	// Sample FIFO and processing stages
	// ********************************
	logic [SW-1:0] fifoData;
	logic          fifoValid;
	wire           adv = ~outValid | outReady;

	apc_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) uFifo (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.inData   (srcData),
		.inValid  (srcValid),
		.inReady  (srcReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (adv)
	);

	// Stage 0 triode, 1 pentode, 2 tape; each feeds the next.
	// The harmonic kernels live elsewhere, so each stage is a full-width register slot.
	logic [SW-1:0] stData [3];
	logic [SW-1:0] dryData [3];
	logic [2:0]    stValid;

	generate
		for (genvar i = 0; i < 3; i++) begin : gStage
			wire [SW-1:0] inWet = (i == 0) ? fifoData : stData[(i == 0) ? 0 : i-1];
			wire [SW-1:0] inDry = (i == 0) ? fifoData : dryData[(i == 0) ? 0 : i-1];
			wire          inVal = (i == 0) ? fifoValid : stValid[(i == 0) ? 0 : i-1];
			always_ff @(posedge clock) begin
				if (sys_rst)
					stValid[i] <= 1'b0;
				else if (adv) begin
					stValid[i] <= inVal;
					stData[i]  <= inWet;
					dryData[i] <= inDry;
				end
			end
		end
	endgenerate

	// ********************************
	// Bypass gain ramp
	// ********************************
	logic [GW-1:0]      gain;
	wire  [GW-1:0]      gainTarget = bypass ? '0 : GMAX;
	wire                sampleOut  = adv & stValid[2];
	wire signed [SW:0]  diff = $signed({stData[2][SW-1], stData[2]}) - $signed({dryData[2][SW-1], dryData[2]});
	wire signed [SW+GW+1:0] prod = diff * $signed({1'b0, gain});
	wire signed [SW+GW+1:0] mixWide = $signed({{(GW+2){dryData[2][SW-1]}}, dryData[2]}) + (prod >>> RAMP_SHIFT);

	// A toggle mid-ramp restarts the ramp from the present gain toward the new end
	always_ff @(posedge clock) begin
		if (sys_rst)
			gain <= GMAX;
		else if (sampleOut && gain != gainTarget)
			gain <= (gain < gainTarget) ? gain + 1'b1 : gain - 1'b1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			outValid <= 1'b0;
			outData  <= '0;
		end else if (adv) begin
			outValid <= stValid[2];
			outData  <= mixWide[SW-1:0];
		end
	end

	// ********************************
	// Overload and peak memory
	// ********************************
	wire           accepted = srcValid & srcReady;
	wire           fullScale = (srcData == {1'b0, {(SW-1){1'b1}}}) | (srcData == {1'b1, {(SW-1){1'b0}}});
	wire [SW-1:0]  magn = srcData[SW-1] ? (~srcData + 1'b1) : srcData;
	wire           newPeak = accepted & (magn > peak);
	apc_pkg::apc_peak_t pkState;
	logic [31:0]   holdCnt;
	logic          timedMode;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overLed   <= 1'b0;
			timedMode <= 1'b0;
		end else begin
			// A sample caught in the clearing cycle still lights the lamp
			overLed   <= (accepted & fullScale) | (overLed & ~clearReq);
			timedMode <= syncJmp[1];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			peak    <= '0;
			holdCnt <= 32'h0;
			pkState <= apc_pkg::APC_PK_HOLD;
		end else if (newPeak) begin
			peak    <= magn;
			holdCnt <= 32'h0;
			pkState <= apc_pkg::APC_PK_HOLD;
		end else if (clearReq) begin
			peak    <= '0;
			holdCnt <= 32'h0;
			pkState <= apc_pkg::APC_PK_HOLD;
		end else begin
			case (pkState)
				apc_pkg::APC_PK_HOLD: begin
					if (timedMode && holdCnt >= 32'(HOLD_CYC - 1)) begin
						holdCnt <= 32'h0;
						pkState <= apc_pkg::APC_PK_DECAY;
					end else if (timedMode)
						holdCnt <= holdCnt + 32'h1;
				end
				apc_pkg::APC_PK_DECAY: begin
					if (holdCnt >= 32'(DECAY_CYC - 1)) begin
						holdCnt <= 32'h0;
						peak    <= peak - (peak >> 3);
					end else
						holdCnt <= holdCnt + 32'h1;
				end
				default: pkState <= apc_pkg::APC_PK_HOLD;
			endcase
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_EXT_RATE: assert property (extSel && syncPres[1] |=> rateCode == apc_pkg::RATE_EXT)
		else $error("external rate not selected");
	AST_LOCK_LED: assert property (lockLed |-> $past(extSel) && $past(syncPres[1]))
		else $error("lock lamp without lock");
	AST_LOSS: assert property (extSel && $fell(syncPres[1]) |=> rateCode == apc_pkg::RATE_44K1 && !lockLed)
		else $error("no fallback on lock loss");
	AST_RECAL: assert property ($changed(rateCode) |-> adcRecal)
		else $error("rate change without recalibration");
	AST_CLEAR: assert property (wrCmd && regWrData[0] && !accepted |=> !overLed && peak == '0)
		else $error("clear did not reset overload and peak");
	AST_RAMP: assert property (gain != gainTarget && sampleOut |=> $changed(gain))
		else $error("gain ramp stalled");
	AST_STEP: assert property (gain != $past(gain) |-> (gain == $past(gain) + 1'b1) || (gain == $past(gain) - 1'b1))
		else $error("gain jumped");
	AST_DITHER: assert property (ditherEn |-> $past(rtDither) && $past(wlDither))
		else $error("dither outside permitted routing");
	AST_OVER: assert property (accepted && fullScale |=> overLed)
		else $error("full-scale sample missed");
	AST_SERIES: assert property (adv && stValid[1] |=> stData[2] == $past(stData[1]))
		else $error("stage order broken");
	AST_WC_EXT: assert property (rateCode == apc_pkg::RATE_EXT && $past(rateCode) == apc_pkg::RATE_EXT
		|=> wordClkOut == $past(clkDly))
		else $error("word clock not following reference");

	COV_LOCK: cover property (lockLed ##1 !lockLed);
	COV_RAMP: cover property (gain == GMAX ##[1:300] gain == '0);
	COV_DECAY: cover property (pkState == apc_pkg::APC_PK_DECAY);
	COV_FULL: cover property (!srcReady && outValid && !outReady);
endmodule

/* src/apc_pkg.sv */
// Shared constants for the audio panel mode control block
package apc_pkg;
	// ********************************
	// Clock and timing
	// ********************************
	localparam int CLK_HZ         = 100000000;
	localparam int PEAK_HOLD_S    = 2;
	localparam int PEAK_HOLD_CYC  = PEAK_HOLD_S * CLK_HZ;
	localparam int DECAY_STEP_CYC = 100000;
	localparam int RAMP_SHIFT     = 6;

	// ********************************
	// Internal sample rates and word-clock half periods
	// ********************************
	localparam int RATE_A_HZ = 44100;
	localparam int RATE_B_HZ = 48000;
	localparam int RATE_C_HZ = 88200;
	localparam int RATE_D_HZ = 96000;
	localparam logic [10:0] HALF_A = 11'(CLK_HZ / (2 * RATE_A_HZ));
	localparam logic [10:0] HALF_B = 11'(CLK_HZ / (2 * RATE_B_HZ));
	localparam logic [10:0] HALF_C = 11'(CLK_HZ / (2 * RATE_C_HZ));
	localparam logic [10:0] HALF_D = 11'(CLK_HZ / (2 * RATE_D_HZ));

	// Effective rate codes; code 3'h4 means the external reference
	localparam logic [2:0] RATE_44K1 = 3'h0;
	localparam logic [2:0] RATE_48K  = 3'h1;
	localparam logic [2:0] RATE_88K2 = 3'h2;
	localparam logic [2:0] RATE_96K  = 3'h3;
	localparam logic [2:0] RATE_EXT  = 3'h4;

	// Routing of the processing chain
	localparam logic [1:0] ROUTE_DA = 2'h0;
	localparam logic [1:0] ROUTE_AD = 2'h1;
	localparam logic [1:0] ROUTE_DD = 2'h2;
	localparam logic [1:0] ROUTE_AA = 2'h3;

	// Word-length groups of the process switch
	localparam logic [1:0] WL_24 = 2'h0;
	localparam logic [1:0] WL_16 = 2'h1;
	localparam logic [1:0] WL_20 = 2'h2;

	// ********************************
	// Register map (byte addresses) and fields
	// ********************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PEAK   = 8'h08;
	localparam logic [7:0] OFS_CMD    = 8'h0C;
	localparam int CTRL_RATE_LSB  = 0;
	localparam int CTRL_EXT_BIT   = 2;
	localparam int CTRL_BYP_BIT   = 3;
	localparam int CTRL_INSEL_BIT = 4;
	localparam int CTRL_ROUTE_LSB = 5;
	localparam int CTRL_WL_LSB    = 7;
	localparam logic [8:0] CTRL_RESET = 9'h000;
	localparam int CMD_CLR_BIT    = 0;

	typedef enum logic [1:0] {
		APC_PK_HOLD  = 2'b01,
		APC_PK_DECAY = 2'b10
	} apc_peak_t;
endpackage
